// ---- include/sscin_pkg.sv ----
package sscin_pkg;
  // ****************************************************************
  // Register map (word offsets are byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IDLE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_POS = 8'h0c;
  localparam logic [7:0] ADDR_CUR = 8'h10;

  // CTRL fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_FALL_BIT = 1;
  localparam int CTRL_DPOL_BIT = 2;
  localparam int CTRL_APOL_BIT = 3;
  localparam int CTRL_IDLE_EN_BIT = 4;
  localparam int CTRL_USE_REG_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h10;

  // STAT fields
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_STILL_BIT = 1;
  localparam int STAT_DIR_BIT = 2;
  localparam int STAT_MODE_BIT = 3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int IDLE_MS = 500;
  localparam int IDLE_CYCLES = IDLE_MS * CLK_MHZ * 1000;
  localparam int CUR_FULL = 100;
  localparam int CUR_IDLE_PCT = 60;
  localparam logic [7:0] CUR_FULL_CODE = 8'h64;
  localparam int MIN_PULSE_NS = 1200;
  localparam int DIR_SETUP_NS = 5000;
  localparam int MAX_RATE_KHZ = 300;
endpackage

// ---- src/sscin_sync.sv ----
`timescale 1ns/1ps
module sscin_sync #(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // Two-stage synchroniser; only the second stage is visible
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ---- src/sscin_top.sv ----
`timescale 1ns/1ps
// Contract
// - Single-pulse mode: one step per active step edge, rising by default.
// - Dual-pulse mode: step input high level requests clockwise steps.
// - Single-pulse mode: direction level picks rotation for following steps.
// - Dual-pulse mode: direction input low level requests counter-clockwise steps.
// - Drive enabled on allow high for sinking wiring, inverted otherwise.
// - Unconnected allow input keeps the drive enabled only while the allow polarity is not inverted.
// - Reset gives single-pulse rising-edge mode; jumper selects dual-pulse mode.
// - Single-pulse mode may step on falling edges instead.
// - Dual-pulse mode has selectable active polarity of the inputs.
// - Idle reduction lowers current setpoint to 60% at standstill.
// - Step rates from zero to 300 kHz are accepted.
module sscin_top
  import sscin_pkg::*;
#(
  parameter int IDLE_COUNT = sscin_pkg::IDLE_CYCLES,
  parameter int POS_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_pulse_in_i,
  input wire logic dir_in_i,
  input wire logic drive_allow_in_i,
  input wire logic pulse_mode_jumper_i,
  input wire logic falling_edge_jumper_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic step_o,
  output logic dir_o,
  output logic drive_en_o,
  output logic standstill_o,
  output logic [7:0] current_pct_o
);
  import sscin_pkg::*;

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [4:0] sync_q;
  logic mode_s;
  logic fall_s;
  logic step_s;
  logic dir_s;
  logic allow_s;
  logic step_d;
  logic dir_d;

  // Straps are pins too, so they share the synchroniser with the pulse inputs
  sscin_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({falling_edge_jumper_i, pulse_mode_jumper_i, drive_allow_in_i, dir_in_i,
          step_pulse_in_i}),
    .q_o(sync_q)
  );

  assign step_s = sync_q[0];
  assign dir_s = sync_q[1];
  assign allow_s = sync_q[2];
  assign mode_s = sync_q[3];
  assign fall_s = sync_q[4];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step_d <= 1'b0;
      dir_d <= 1'b0;
    end
    else
    begin
      step_d <= step_s;
      dir_d <= dir_s;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [5:0] ctrl;
  logic [31:0] idle_limit;
  logic [POS_W-1:0] position;
  logic [31:0] idle_cnt;
  logic still;
  logic dual_mode;
  logic fall_sel;
  logic dual_pol;
  logic allow_pol;
  logic wb_hit;
  logic wb_valid;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign wb_valid = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wb_hit = (wb_adr_i == ADDR_CTRL) || (wb_adr_i == ADDR_IDLE) ||
                  (wb_adr_i == ADDR_STAT) || (wb_adr_i == ADDR_POS) ||
                  (wb_adr_i == ADDR_CUR);

  // Straps win unless software explicitly takes over the mode selection
  assign dual_mode = ctrl[CTRL_USE_REG_BIT] ? ctrl[CTRL_MODE_BIT]
                                            : mode_s;
  assign fall_sel = ctrl[CTRL_USE_REG_BIT] ? ctrl[CTRL_FALL_BIT]
                                           : fall_s;
  assign dual_pol = ctrl[CTRL_DPOL_BIT];
  assign allow_pol = ctrl[CTRL_APOL_BIT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= CTRL_RESET;
      idle_limit <= 32'(IDLE_COUNT);
    end
    // Writes commit at the edge where the master samples ack, while the request stands
    else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i)
    begin
      if (wb_adr_i == ADDR_CTRL)
      begin
        ctrl <= 6'(merge_bytes({26'h0, ctrl}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == ADDR_IDLE)
      begin
        idle_limit <= merge_bytes(idle_limit, wb_dat_i, wb_sel_i);
      end
    end
  end

  // ****************************************************************
  // Wishbone answer: one wait-free cycle, ack or err
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_valid && wb_hit;
      wb_err_o <= wb_valid && !wb_hit;
      wb_dat_o <= 32'h0;
      if (wb_valid && !wb_we_i)
      begin
        case (wb_adr_i)
          ADDR_CTRL: wb_dat_o <= {26'h0, ctrl};
          ADDR_IDLE: wb_dat_o <= idle_limit;
          ADDR_STAT: wb_dat_o <= {28'h0, dual_mode, dir_o, still, drive_en_o};
          ADDR_POS: wb_dat_o <= 32'(position);
          ADDR_CUR: wb_dat_o <= {24'h0, current_pct_o};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Step decode
  // ****************************************************************
  logic rise;
  logic fall;
  logic cw_level;
  logic ccw_level;
  logic cw_prev;
  logic ccw_prev;
  logic step_evt;
  logic step_dir;

  // Edge detection on the synchronised copy resolves pulses down to the
  // clock period, well inside the minimum pulse width and peak rate.
  assign rise = step_s && !step_d;
  assign fall = !step_s && step_d;
  // Polarity select maps isolator conduction onto active request
  assign cw_level = dual_pol ? !step_s : step_s;
  assign ccw_level = dual_pol ? dir_s : !dir_s;
  assign cw_prev = dual_pol ? !step_d : step_d;
  assign ccw_prev = dual_pol ? dir_d : !dir_d;

  always_comb
  begin
    step_evt = 1'b0;
    step_dir = dir_o;
    if (!dual_mode)
    begin
      step_evt = fall_sel ? fall : rise;
      step_dir = dir_s;
    end
    else if (cw_level && !cw_prev)
    begin
      step_evt = 1'b1;
      step_dir = 1'b1;
    end
    else if (ccw_level && !ccw_prev)
    begin
      step_evt = 1'b1;
      step_dir = 1'b0;
    end
  end

  // Drive allow: open input floats high through the isolator idle state
  assign drive_en_o = allow_pol ? !allow_s : allow_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step_o <= 1'b0;
      dir_o <= 1'b0;
      position <= '0;
    end
    else
    begin
      step_o <= step_evt && drive_en_o;
      if (step_evt && drive_en_o)
      begin
        dir_o <= step_dir;
        position <= step_dir ? position + 1'b1 : position - 1'b1;
      end
    end
  end

  // ****************************************************************
  // Standstill detection and current reduction
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idle_cnt <= 32'h0;
      still <= 1'b0;
    end
    else if (step_o)
    begin
      idle_cnt <= 32'h0;
      still <= 1'b0;
    end
    else if (idle_cnt >= idle_limit)
    begin
      still <= 1'b1;
    end
    else
    begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  assign standstill_o = still;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      current_pct_o <= CUR_FULL_CODE;
    end
    else if (still && ctrl[CTRL_IDLE_EN_BIT])
    begin
      current_pct_o <= 8'(CUR_IDLE_PCT);
    end
    else
    begin
      current_pct_o <= CUR_FULL_CODE;
    end
  end
endmodule

// ---- tb/sscin_ctrl_model.sv ----
`timescale 1ns/1ps
module sscin_ctrl_model (
  input wire logic clk_i,
  output logic step_o,
  output logic dir_o
);
  initial
  begin
    step_o = 1'b0;
    dir_o = 1'b1;
  end
  task automatic set_dir(input logic d);
    dir_o <= d;
    repeat (500) @(posedge clk_i);
  endtask
  // 170 cycles each phase keeps pulses wide and the rate below the limit
  task automatic pulse(input logic counterclockwise_step_req);
    repeat (2)
    begin
      if (counterclockwise_step_req)
        dir_o <= ~dir_o;
      else
        step_o <= ~step_o;
      repeat (170) @(posedge clk_i);
    end
  endtask
endmodule

// ---- tb/sscin_top_asserts.sv ----
`timescale 1ns/1ps
module sscin_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_pulse_in_i,
  input wire logic dir_in_i,
  input wire logic drive_allow_in_i,
  input wire logic pulse_mode_jumper_i,
  input wire logic falling_edge_jumper_i,
  input wire logic step_o,
  input wire logic dir_o,
  input wire logic drive_en_o,
  input wire logic standstill_o,
  input wire logic [7:0] current_pct_o,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  import sscin_pkg::*;
  logic dpol;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Shadow of the dual-mode polarity bit, taken when a control write is acknowledged
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dpol <= 1'b0;
    end
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
             wb_adr_i == ADDR_CTRL)
    begin
      dpol <= wb_dat_i[CTRL_DPOL_BIT];
    end
  end
  // Two sync stages and the edge detect sit between a pin edge and step_o
  step_rise_a: assert property (
    $rose(step_pulse_in_i) && !pulse_mode_jumper_i && !falling_edge_jumper_i && drive_en_o
    |-> ##[2:5] step_o) else $error("no step on rising edge");
  step_fall_a: assert property (
    $fell(step_pulse_in_i) && !pulse_mode_jumper_i && falling_edge_jumper_i && drive_en_o
    |-> ##[2:5] step_o) else $error("no step on falling edge");
  dual_cw_a: assert property (
    pulse_mode_jumper_i && drive_en_o &&
    (dpol ? $fell(step_pulse_in_i) : $rose(step_pulse_in_i))
    |-> ##[2:5] (step_o && dir_o)) else $error("no clockwise step");
  dual_ccw_a: assert property (
    pulse_mode_jumper_i && drive_en_o && (dpol ? $rose(dir_in_i) : $fell(dir_in_i))
    |-> ##[2:5] (step_o && !dir_o)) else $error("no reverse step");
  one_step_a: assert property (step_o |=> !step_o) else $error("step too wide");
  allow_follow_a: assert property (
    $changed(drive_allow_in_i) |-> ##[1:3] (drive_en_o == drive_allow_in_i))
    else $error("enable does not follow allow");
  still_cur_a: assert property (
    $rose(standstill_o) |=> current_pct_o == 8'h3c) else $error("idle current wrong");
  run_cur_a: assert property (
    step_o |-> ##2 (!standstill_o && current_pct_o == 8'h64)) else $error("no full current");
endmodule
bind sscin_top sscin_top_asserts sscin_top_asserts_i (.clk_i, .rst_i, .step_pulse_in_i,
  .dir_in_i, .drive_allow_in_i, .pulse_mode_jumper_i, .falling_edge_jumper_i, .step_o,
  .dir_o, .drive_en_o, .standstill_o, .current_pct_o, .wb_adr_i, .wb_dat_i, .wb_sel_i,
  .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import sscin_pkg::*;
  localparam int IDLE_SIM = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic allow = 1'b1;
  logic mode_j = 1'b0;
  logic fall_j = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic pul, dirl, ack, err, step, dir, en, still, e, d;
  logic [7:0] cur;
  logic [31:0] rdat, q, pos;
  int bad_count = 0;
  int checks = 0;
  int steps = 0;
  int n;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (step) steps <= steps + 1;
  sscin_ctrl_model sscin_ctrl_model_i (.clk_i, .step_o(pul), .dir_o(dirl));
  sscin_top #(.IDLE_COUNT(IDLE_SIM)) sscin_top_i (.clk_i, .rst_i, .step_pulse_in_i(pul),
    .dir_in_i(dirl), .drive_allow_in_i(allow), .pulse_mode_jumper_i(mode_j),
    .falling_edge_jumper_i(fall_j), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .step_o(step), .dir_o(dir), .drive_en_o(en), .standstill_o(still),
    .current_pct_o(cur));
  function automatic logic [31:0] exp_pos(input logic [31:0] p, input int k, input logic f);
    return f ? p + k : p - k;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
    adr <= a;
    we <= w;
    wdat <= v;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk_i);
    while (!(ack || err))
    begin
      @(posedge clk_i);
    end
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic run(input int cnt, input logic counterclockwise_step_req, input int exp_cnt);
    int s0;
    s0 = steps;
    repeat (cnt) sscin_ctrl_model_i.pulse(counterclockwise_step_req);
    repeat (8) @(posedge clk_i);
    chk(steps - s0, exp_cnt, "step count");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    n = $urandom(32'h6796);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(ADDR_CTRL, 1'b0, 32'h0);
    chk(q, 32'h10, "ctrl reset");
    bus(ADDR_IDLE, 1'b0, 32'h0);
    chk(q, IDLE_SIM, "idle reset");
    bus(8'h20, 1'b1, 32'hff);
    chk(e, 1'b1, "unmapped");
    for (int i = 0; i < 4; i++)
    begin
      fall_j <= i[1];
      d = 1'($urandom);
      n = 1 + $urandom % 3;
      bus(ADDR_POS, 1'b0, 32'h0);
      pos = exp_pos(q, n, d);
      sscin_ctrl_model_i.set_dir(d);
      run(n, 1'b0, n);
      chk(dir, d, "direction");
      bus(ADDR_POS, 1'b0, 32'h0);
      chk(q, pos, "position");
    end
    repeat (IDLE_SIM + 10) @(posedge clk_i);
    chk(still, 1'b1, "standstill");
    chk(cur, 8'h3c, "idle current");
    allow <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk(en, 1'b0, "allow low");
    run(1, 1'b0, 0);
    allow <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(en, 1'b1, "allow high");
    bus(ADDR_CTRL, 1'b1, 32'h18);
    chk(en, 1'b0, "allow inverted");
    bus(ADDR_CTRL, 1'b1, 32'h10);
    bus(ADDR_IDLE, 1'b1, 32'h1000);
    bus(ADDR_IDLE, 1'b0, 32'h0);
    chk(q, 32'h1000, "idle write");
    sscin_ctrl_model_i.set_dir(1'b1);
    mode_j <= 1'b1;
    fall_j <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2)
        bus(ADDR_CTRL, 1'b1, 32'h14);
      d = 1'($urandom);
      run(1, d, 1);
      chk(dir, !d, "dual direction");
    end
    chk(cur, 8'h64, "full current");
    chk(still, 1'b0, "standstill cleared");
    report_and_stop();
  end
  initial
  begin
    #400_000;
    bad_count++;
    report_and_stop();
  end
endmodule
